// File: core/cpw_defs.vh
`ifndef CPW_DEFS_VH
`define CPW_DEFS_VH

// ----------------------------------------
// Clock and limits
// ----------------------------------------
`define CPW_CLK_HZ 25'h1312d00
`define CPW_FREQ_MIN 16'h0001
`define CPW_FREQ_MAX 16'h4e20
`define CPW_DUTY_FULL 16'h03e8
`define CPW_DUTY_DEN 35'h000003e8

// ----------------------------------------
// Output type codes
// ----------------------------------------
`define CPW_TYPE_OFF 8'h00
`define CPW_TYPE_FREQ 8'h28
`define CPW_TYPE_PWM 8'h32
`define CPW_TYPE_DIG 8'h3c
`define CPW_TYPE_MIX 8'h46

// ----------------------------------------
// Register offsets and upper address match
// ----------------------------------------
`define CPW_OFF_TYPE 8'h00
`define CPW_OFF_FIXED 8'h04
`define CPW_OFF_AMP 8'h08
`define CPW_OFF_LOW 8'h0c
`define CPW_OFF_HIGH 8'h10
`define CPW_OFF_CMIN 8'h14
`define CPW_OFF_CMAX 8'h18
`define CPW_OFF_CMD 8'h1c
`define CPW_OFF_MFLO 8'h20
`define CPW_OFF_MFHI 8'h24
`define CPW_OFF_STAT 8'h28
`define CPW_OFF_AFREQ 8'h2c
`define CPW_OFF_ADUTY 8'h30
`define CPW_ADDR_HI_ZERO 24'h000000

// ----------------------------------------
// Status and HTRANS bit positions
// ----------------------------------------
`define CPW_ST_PIN 0
`define CPW_ST_ERR 1
`define CPW_ST_DIG 2
`define CPW_HTRANS_ACT 1

// ----------------------------------------
// Reset values and per-type defaults
// ----------------------------------------
`define CPW_RST_ZERO 16'h0000
`define CPW_RST_CMAX 16'hffff
`define CPW_RST_PERIOD 25'h0000001
`define CPW_DEF_FREQ_DUTY 16'h01f4
`define CPW_DEF_PWM_FREQ 16'h03e8
`define CPW_DEF_DIG_HIGH 16'h0001
`define CPW_DEF_MFLO 16'h0064
`define CPW_DEF_MFHI 16'h03e8

`endif

// File: core/cpw_top.v
`include "cpw_defs.vh"

module cpw_top #(
    parameter [24:0] CLK_HZ = `CPW_CLK_HZ
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    output reg pwm_out,
    output reg amp_12v_sel
);

    // ----------------------------------------
    // Setting registers
    // ----------------------------------------
    reg [7:0] out_type;
    reg [15:0] fixed_value;
    reg amp_12v;
    reg [15:0] low_end_output_value;
    reg [15:0] high_end_output_value;
    reg [15:0] cmd_min;
    reg [15:0] cmd_max;
    reg [15:0] command;
    reg [15:0] mix_freq_lo;
    reg [15:0] mix_freq_hi;

    // ----------------------------------------
    // Bus and generator state
    // ----------------------------------------
    reg wr_pend;
    reg [7:0] wr_addr;
    reg [24:0] cnt;
    reg [24:0] period_r;
    reg [24:0] high_r;
    reg [15:0] act_freq;
    reg [15:0] act_duty;
    reg dig_on;
    reg type_restart;

    // ----------------------------------------
    // Linear map
    // ----------------------------------------
    // Signed span keeps inverse responses exact; x is pre-clamped
    function [15:0] lin_map;
        input [15:0] x;
        input [15:0] xlo;
        input [15:0] xhi;
        input [15:0] ylo;
        input [15:0] yhi;
        reg signed [17:0] dy;
        reg signed [17:0] dx;
        reg signed [17:0] ox;
        reg signed [35:0] prod;
        reg signed [35:0] q;
        reg signed [35:0] y;
        begin
            dy = $signed({2'b00, yhi}) - $signed({2'b00, ylo});
            dx = $signed({2'b00, xhi}) - $signed({2'b00, xlo});
            ox = $signed({2'b00, x}) - $signed({2'b00, xlo});
            prod = dy * ox;
            if (dx > $signed(18'h00000)) begin
                q = prod / dx;
            end else begin
                q = 36'h000000000;
            end
            y = $signed({20'h00000, ylo}) + q;
            lin_map = y[15:0];
        end
    endfunction

    function [15:0] clamp_freq;
        input [15:0] f;
        begin
            clamp_freq = (f < `CPW_FREQ_MIN) ? `CPW_FREQ_MIN :
                ((f > `CPW_FREQ_MAX) ? `CPW_FREQ_MAX : f);
        end
    endfunction

    function [15:0] clamp_duty;
        input [15:0] d;
        begin
            clamp_duty = (d > `CPW_DUTY_FULL) ? `CPW_DUTY_FULL : d;
        end
    endfunction

    // ----------------------------------------
    // Command clamp and mapping
    // ----------------------------------------
    wire cfg_err = (cmd_min >= cmd_max);
    wire [15:0] cmd_clamped = (command < cmd_min) ? cmd_min :
        ((command > cmd_max) ? cmd_max : command);
    wire [15:0] map_main = lin_map(cmd_clamped, cmd_min, cmd_max,
        low_end_output_value, high_end_output_value);
    wire [15:0] map_mfreq = lin_map(cmd_clamped, cmd_min, cmd_max,
        mix_freq_lo, mix_freq_hi);

    reg [15:0] next_freq;
    reg [15:0] next_duty;
    reg run;
    reg mode_dig;

    always @* begin
        next_freq = `CPW_FREQ_MIN;
        next_duty = `CPW_RST_ZERO;
        run = 1'b0;
        mode_dig = 1'b0;
        case (out_type)
            `CPW_TYPE_FREQ: begin
                next_freq = clamp_freq(map_main);
                next_duty = clamp_duty(fixed_value);
                run = 1'b1;
            end
            `CPW_TYPE_PWM: begin
                next_freq = clamp_freq(fixed_value);
                next_duty = clamp_duty(map_main);
                run = 1'b1;
            end
            `CPW_TYPE_DIG: begin
                run = 1'b1;
                mode_dig = 1'b1;
            end
            `CPW_TYPE_MIX: begin
                next_freq = clamp_freq(map_mfreq);
                next_duty = clamp_duty(map_main);
                run = 1'b1;
            end
            default: run = 1'b0;
        endcase
        if (cfg_err) begin
            run = 1'b0;
        end
    end

    // Dividers are combinational; sampled at period wrap or type restart
    wire [24:0] period_w = CLK_HZ / {9'h000, next_freq};
    wire [34:0] high_prod = {10'h000, period_w} * {19'h00000, next_duty};
    wire [34:0] high_q = high_prod / `CPW_DUTY_DEN;
    wire [24:0] high_w = high_q[24:0];

    // ----------------------------------------
    // Per-type defaults
    // ----------------------------------------
    reg [15:0] def_fixed;
    reg [15:0] def_low;
    reg [15:0] def_high;

    always @* begin
        def_fixed = `CPW_RST_ZERO;
        def_low = `CPW_RST_ZERO;
        def_high = `CPW_RST_ZERO;
        case (hwdata[7:0])
            `CPW_TYPE_FREQ: begin
                def_fixed = `CPW_DEF_FREQ_DUTY;
                def_low = `CPW_FREQ_MIN;
                def_high = `CPW_FREQ_MAX;
            end
            `CPW_TYPE_PWM: begin
                def_fixed = `CPW_DEF_PWM_FREQ;
                def_high = `CPW_DUTY_FULL;
            end
            `CPW_TYPE_DIG: def_high = `CPW_DEF_DIG_HIGH;
            `CPW_TYPE_MIX: def_high = `CPW_DUTY_FULL;
            default: def_fixed = `CPW_RST_ZERO;
        endcase
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    wire acc = hsel & htrans[`CPW_HTRANS_ACT] & hready;
    wire hit = (haddr[31:8] == `CPW_ADDR_HI_ZERO);
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        case (haddr[7:0])
            `CPW_OFF_TYPE: rd_mux = {24'h000000, out_type};
            `CPW_OFF_FIXED: rd_mux = {16'h0000, fixed_value};
            `CPW_OFF_AMP: rd_mux = {31'h00000000, amp_12v};
            `CPW_OFF_LOW: rd_mux = {16'h0000, low_end_output_value};
            `CPW_OFF_HIGH: rd_mux = {16'h0000, high_end_output_value};
            `CPW_OFF_CMIN: rd_mux = {16'h0000, cmd_min};
            `CPW_OFF_CMAX: rd_mux = {16'h0000, cmd_max};
            `CPW_OFF_CMD: rd_mux = {16'h0000, command};
            `CPW_OFF_MFLO: rd_mux = {16'h0000, mix_freq_lo};
            `CPW_OFF_MFHI: rd_mux = {16'h0000, mix_freq_hi};
            `CPW_OFF_STAT: begin
                rd_mux[`CPW_ST_PIN] = pwm_out;
                rd_mux[`CPW_ST_ERR] = cfg_err;
                rd_mux[`CPW_ST_DIG] = dig_on;
            end
            `CPW_OFF_AFREQ: rd_mux = {16'h0000, act_freq};
            `CPW_OFF_ADUTY: rd_mux = {16'h0000, act_duty};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // Zero wait states; unmapped reads give zero, writes vanish
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            type_restart <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= acc & hwrite & hit;
            wr_addr <= haddr[7:0];
            // Mode change flag for the timer
            type_restart <= wr_pend & (wr_addr == `CPW_OFF_TYPE) & (hwdata[7:0] != out_type);
            if (acc & ~hwrite) begin
                hrdata <= hit ? rd_mux : 32'h00000000;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_type <= `CPW_TYPE_OFF;
            fixed_value <= `CPW_RST_ZERO;
            amp_12v <= 1'b0;
            low_end_output_value <= `CPW_RST_ZERO;
            high_end_output_value <= `CPW_RST_ZERO;
            cmd_min <= `CPW_RST_ZERO;
            cmd_max <= `CPW_RST_CMAX;
            command <= `CPW_RST_ZERO;
            mix_freq_lo <= `CPW_DEF_MFLO;
            mix_freq_hi <= `CPW_DEF_MFHI;
        end else if (wr_pend) begin
            case (wr_addr)
                `CPW_OFF_TYPE: begin
                    out_type <= hwdata[7:0];
                    // Same-type write keeps user settings intact
                    if (hwdata[7:0] != out_type) begin
                        fixed_value <= def_fixed;
                        low_end_output_value <= def_low;
                        high_end_output_value <= def_high;
                        mix_freq_lo <= `CPW_DEF_MFLO;
                        mix_freq_hi <= `CPW_DEF_MFHI;
                    end
                end
                `CPW_OFF_FIXED: fixed_value <= hwdata[15:0];
                `CPW_OFF_AMP: amp_12v <= hwdata[0];
                `CPW_OFF_LOW: low_end_output_value <= hwdata[15:0];
                `CPW_OFF_HIGH: high_end_output_value <= hwdata[15:0];
                `CPW_OFF_CMIN: cmd_min <= hwdata[15:0];
                `CPW_OFF_CMAX: cmd_max <= hwdata[15:0];
                `CPW_OFF_CMD: command <= hwdata[15:0];
                `CPW_OFF_MFLO: mix_freq_lo <= hwdata[15:0];
                `CPW_OFF_MFHI: mix_freq_hi <= hwdata[15:0];
                default: out_type <= out_type;
            endcase
        end
    end

    // ----------------------------------------
    // Timer generator, single channel
    // ----------------------------------------
    // Settings take effect at a period boundary, so no runt pulses;
    // a type change starts a fresh period so a slow old one cannot stall it.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 25'h0000000;
            period_r <= `CPW_RST_PERIOD;
            high_r <= 25'h0000000;
            act_freq <= `CPW_RST_ZERO;
            act_duty <= `CPW_RST_ZERO;
        end else if (type_restart || (cnt >= period_r - `CPW_RST_PERIOD)) begin
            cnt <= 25'h0000000;
            period_r <= period_w;
            high_r <= high_w;
            act_freq <= next_freq;
            act_duty <= next_duty;
        end else begin
            cnt <= cnt + 25'h0000001;
        end
    end

    // On/off state: on at maximum command, off at minimum, held between
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dig_on <= 1'b0;
        end else if (!mode_dig || cfg_err) begin
            dig_on <= 1'b0;
        end else if (cmd_clamped == cmd_max) begin
            dig_on <= 1'b1;
        end else if (cmd_clamped == cmd_min) begin
            dig_on <= 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pwm_out <= 1'b0;
            amp_12v_sel <= 1'b0;
        end else begin
            amp_12v_sel <= amp_12v;
            if (!run) begin
                pwm_out <= 1'b0;
            end else if (mode_dig) begin
                pwm_out <= dig_on;
            end else begin
                pwm_out <= (cnt < high_r);
            end
        end
    end

endmodule // cpw_top

// File: dv/cpw_ecm_model.sv
// ----------------------------------------
// Receiving control module: period and high time
// ----------------------------------------
module cpw_ecm_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pwm_out,
    output logic [15:0] hi_len,
    output logic [15:0] per_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic prev;
    logic [15:0] cnt;
    logic [15:0] hc;
    // Measured rise to rise, so a constant level keeps the last figures
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {prev, cnt, hc, hi_len, per_len} <= '0;
        end else begin
            prev <= pwm_out;
            if (pwm_out && !prev) begin
                {per_len, hi_len} <= {cnt, hc};
                {cnt, hc} <= {16'h0001, 16'h0001};
            end else begin
                cnt <= cnt + 16'h0001;
                hc <= hc + {15'h0, pwm_out};
            end
        end
    end
endmodule // cpw_ecm_model

// File: dv/cpw_top_props.sv
// ----------------------------------------
// Port checker
// ----------------------------------------
module cpw_top_props (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire pwm_out,
    input wire amp_12v_sel
);
    timeunit 1ns;
    timeprecision 1ns;
    wire ap = hsel & htrans[1] & hready;
    reg pv, pw, rq, aw, av, typed;
    reg [31:0] pa;
    reg [7:0] ctyp;
    // Shadow of the type and amplitude writes, committed at data-phase end
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {pv, pw, rq, aw, av, typed, pa, ctyp} <= '0;
        end else begin
            {pv, pw, pa, rq} <= {ap, hwrite, haddr, ap & !hwrite};
            aw <= pv & pw & (pa == 32'h8);
            if (pv & pw & (pa == 32'h8)) begin
                av <= hwdata[0];
            end
            if (pv & pw & (pa == 32'h0)) begin
                {ctyp, typed} <= {hwdata[7:0], 1'b1};
            end
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    ready_high_a: assert property (hreadyout) else $error("hreadyout low");
    resp_okay_a: assert property (!hresp) else $error("hresp not okay");
    unmapped_zero_a: assert property (ap && !hwrite && (haddr[31:8] != 24'h0
        || haddr[7:0] > 8'h30) |=> hrdata == 32'h0) else $error("unmapped read");
    read_hold_a: assert property (!rq |-> $stable(hrdata)) else $error("hrdata moved");
    upper_zero_a: assert property (ap && !hwrite |=> hrdata[31:16] == 16'h0)
        else $error("upper bits set");
    type_read_a: assert property (ap && !hwrite && haddr == 32'h0
        |=> hrdata == {24'h0, $past(ctyp)}) else $error("type readback");
    amp_follow_a: assert property (aw |-> ##[0:1] amp_12v_sel == av)
        else $error("amplitude not applied");
    amp_cause_a: assert property ($changed(amp_12v_sel) |-> aw || $past(aw))
        else $error("amplitude moved alone");
    off_low_a: assert property (!typed |-> !pwm_out) else $error("pin active");
endmodule // cpw_top_props

bind cpw_top cpw_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_out(pwm_out),
    .amp_12v_sel(amp_12v_sel));

// File: dv/cpw_top_test.sv
module cpw_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, pwm_out, amp_12v_sel;
    logic [15:0] hi_len, per_len;
    int err_total = 0, check_count = 0;
    always #25 hclk = ~hclk;
    // Short clock figure: 1 kHz gives a 20-cycle period
    cpw_top #(.CLK_HZ(25'h0004e20)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pwm_out(pwm_out), .amp_12v_sel(amp_12v_sel));
    cpw_ecm_model ecm (.hclk(hclk), .hresetn(hresetn), .pwm_out(pwm_out),
        .hi_len(hi_len), .per_len(per_len));
    // ----------------------------------------
    // Bus and check tasks
    // ----------------------------------------
    task final_report;
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            err_total++;
            final_report;
        end
    endtask
    task bus(input logic w, input logic [8:0] a, input logic [31:0] d);
        {hsel, hwrite, htrans} <= {1'b1, w, 2'b10};
        haddr <= {23'h0, a};
        rdy;
        {htrans, hwdata} <= {2'b00, d};
        rdy;
        q = hrdata;
    endtask
    // Idle edge after each write so reloads land before the next read
    task wr(input logic [8:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        @(posedge hclk);
    endtask
    task rd(input logic [8:0] a, input logic [31:0] e, input string m);
        bus(1'b0, a, 32'h0);
        chk(q, e, m);
    endtask
    task meas(input logic [15:0] p, input logic [15:0] h);
        repeat (150) @(posedge hclk);
        chk({16'h0, per_len}, {16'h0, p}, "period");
        chk({16'h0, hi_len}, {16'h0, h}, "high time");
    endtask
    task pin(input logic e);
        // Long enough for a new duty to reach the next period wrap
        repeat (25) @(posedge hclk);
        chk({31'h0, pwm_out}, {31'h0, e}, "pin");
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        rd(9'h00, 32'h0, "type reset");
        rd(9'h18, 32'hffff, "cmax reset");
        rd(9'h20, 32'h64, "mflo reset");
        rd(9'h24, 32'h3e8, "mfhi reset");
        rd(9'h100, 32'h0, "unmapped");
        pin(1'b0);
    endtask
    task t_types;
        static logic [7:0] ty [4] = '{8'h28, 8'h32, 8'h3c, 8'h46};
        static logic [15:0] fx [4] = '{16'h01f4, 16'h03e8, 16'h0000, 16'h0000};
        static logic [15:0] hx [4] = '{16'h4e20, 16'h03e8, 16'h0001, 16'h03e8};
        for (int i = 0; i < 4; i++) begin
            wr(9'h00, {24'h0, ty[i]});
            rd(9'h04, {16'h0, fx[i]}, "fixed default");
            rd(9'h10, {16'h0, hx[i]}, "high default");
        end
        wr(9'h04, 32'h7);
        wr(9'h00, 32'h46);
        rd(9'h04, 32'h7, "same type kept");
    endtask
    task t_pwm;
        wr(9'h00, 32'h32);
        wr(9'h18, 32'h3e8);
        wr(9'h1c, 32'hfa);
        meas(16'h14, 16'h5);
        rd(9'h30, 32'hfa, "act duty");
        rd(9'h2c, 32'h3e8, "act freq");
        wr(9'h0c, 32'h3e8);
        wr(9'h10, 32'h0);
        meas(16'h14, 16'hf);
        // Full duty at every step, so the last rise is the 750 one
        wr(9'h10, 32'h3e8);
        wr(9'h1c, 32'h7d0);
        wr(9'h0c, 32'h0);
        meas(16'h14, 16'hf);
        pin(1'b1);
        rd(9'h30, 32'h3e8, "clamped duty");
    endtask
    task t_freq;
        wr(9'h00, 32'h28);
        wr(9'h0c, 32'h1f4);
        wr(9'h10, 32'h3e8);
        wr(9'h1c, 32'h1f4);
        meas(16'h1a, 16'hd);
        rd(9'h2c, 32'h2ee, "freq mode freq");
        wr(9'h1c, 32'h7d0);
        meas(16'h14, 16'ha);
        rd(9'h2c, 32'h3e8, "clamped freq");
        wr(9'h1c, 32'h1f4);
    endtask
    task t_mix;
        wr(9'h00, 32'h46);
        meas(16'h24, 16'h12);
    endtask
    task t_dig;
        wr(9'h00, 32'h3c);
        wr(9'h08, 32'h1);
        @(posedge hclk);
        chk({31'h0, amp_12v_sel}, 32'h1, "amp 12v");
        wr(9'h1c, 32'h3e8);
        pin(1'b1);
        rd(9'h28, 32'h5, "status on");
        wr(9'h1c, 32'h1f4);
        pin(1'b1);
        wr(9'h1c, 32'h0);
        pin(1'b0);
        wr(9'h08, 32'h0);
        @(posedge hclk);
        chk({31'h0, amp_12v_sel}, 32'h0, "amp 5v");
    endtask
    task t_err;
        wr(9'h14, 32'h3e8);
        bus(1'b0, 9'h28, 32'h0);
        chk(q & 32'h3, 32'h2, "cmin error");
        wr(9'h14, 32'h0);
        wr(9'h00, 32'h32);
        wr(9'h1c, 32'h1f4);
        meas(16'h14, 16'ha);
        wr(9'h1c, 32'h3e8);
        pin(1'b1);
        wr(9'h00, 32'h0);
        meas(16'h14, 16'ha);
        pin(1'b0);
    endtask
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_types;
        t_pwm;
        t_freq;
        t_mix;
        t_dig;
        t_err;
        final_report;
    end
endmodule // cpw_top_test
